// file: core/amp_ctl_consts.svh
`ifndef AMP_CTL_CONSTS_SVH
`define AMP_CTL_CONSTS_SVH

// frame layout: 4 address bits then 8 data bits
`define FRAME_BITS      12
`define ADDR_BITS       4
`define DATA_BITS       8
`define ADDR_POWER_GAIN 4'h0
`define ADDR_INIT       4'h1
// power/gain field positions
`define POWER_CODE_HI   7
`define POWER_CODE_LO   6
`define GAIN_CODE_HI    5
`define GAIN_CODE_LO    0
// recommended defaults, used as reset values
`define POWER_CODE_RST  2'h3
`define GAIN_CODE_RST   6'h3F
`define INIT_RST        8'hFF
// gain in dB = gain code minus this offset (63 -> 36 dB)
`define GAIN_DB_OFFSET  27
// power-up wait before first write
`define POWERUP_WAIT_US 100
`define POWERUP_WAIT_CYC ((`POWERUP_WAIT_US * 1000 + 9) / 10)
// link clock divider: half period in system cycles (80 ns)
`define LINK_HALF_CYC   8
// control register offsets of the controller end
`define CTL_REG_CMD     4'h0
`define CTL_REG_STATUS  4'h1
`define CTL_REG_TRANSMIT_ENABLE    4'h2

`endif

// file: core/amp_ctl_pkg.sv
`default_nettype none
package amp_ctl_pkg;
  typedef enum logic [1:0] {
    CTL_IDLE  = 2'b00,
    CTL_SHIFT = 2'b01,
    CTL_END   = 2'b10
  } ctl_state_t;
endpackage
`default_nettype wire

// file: core/amp_link_if.sv
`timescale 1ns/1ns
`default_nettype none
// three-wire write-only control link plus transmit enable
interface amp_link_if;
  logic sclk;
  logic sdata;
  logic sel_n;
  logic transmit_enable;
  modport ctrl (output sclk, output sdata, output sel_n, output transmit_enable);
  modport amp  (input sclk, input sdata, input sel_n, input transmit_enable);
endinterface
`default_nettype wire

// file: core/amp_serial_port.sv
`timescale 1ns/1ns
`default_nettype none
`include "amp_ctl_consts.svh"
module amp_serial_port
  import amp_ctl_pkg::*;
(
  input  wire logic       mclk_in,          // system clock 100 MHz
  input  wire logic       sys_rst_in,       // sync reset, active high
  amp_link_if.amp         link,             // serial link from controller
  output logic [1:0]      power_code_out,   // applied power code
  output logic [5:0]      gain_code_out,    // applied gain code
  output logic signed [6:0] gain_db_out,    // typical gain in dB
  output logic [7:0]      init_value_out,   // applied init register
  output logic            init_done_out,    // init register holds zero
  output logic            transmit_on_out   // transmit mode
);
  // positions of the link pins in the synchroniser bank
  localparam int unsigned PIN_SCLK = 0;
  localparam int unsigned PIN_SEL  = 1;
  localparam int unsigned PIN_TRANSMIT_ENABLE = 2;
  localparam int unsigned PIN_SDA  = 3;
  localparam int unsigned NUM_PINS = 4;

  logic [NUM_PINS-1:0] pin_raw;        // link pins as they arrive
  logic [NUM_PINS-1:0] pin_meta_q;     // first synchroniser stage
  logic [NUM_PINS-1:0] pin_sync_q;     // second stage, the only one read
  logic                sclk_sync;      // synchronised link clock
  logic                sel_n_sync;     // synchronised select, active low
  logic                transmit_enable_sync;      // synchronised transmit enable
  logic                sda_sync;       // synchronised serial data
  logic                sclk_d1_q;      // link clock one cycle back
  logic                sel_n_d1_q;     // select one cycle back
  logic                sclk_rise;      // take one bit
  logic                sel_rise;       // frame closed
  logic [11:0]         shift_q;        // assembled frame, msb first
  logic [3:0]          count_q;        // bits seen in this frame
  logic                frame_full;     // exactly twelve bits seen
  logic [3:0]          frame_addr;     // address field of the frame
  logic [7:0]          frame_data;     // data field of the frame
  logic                hit_pg;         // closed frame aims at power/gain
  logic                hit_init;       // closed frame aims at init
  logic [7:0]          pend_pg_q;      // power/gain waiting to apply
  logic [7:0]          pend_init_q;    // init waiting to apply
  logic                pend_pg_v_q;    // apply power/gain this cycle
  logic                pend_init_v_q;  // apply init this cycle
  logic signed [6:0]   gain_db_next;   // typical gain of the pending code

  // pins gathered in a fixed order
  assign pin_raw = {link.sdata, link.transmit_enable, link.sel_n, link.sclk};

  // two flops per pin; the first stage may be metastable, so nothing else reads it
  always_ff @(posedge mclk_in) begin
    pin_meta_q <= pin_raw;
    pin_sync_q <= pin_meta_q;
  end

  // named views of the second stage
  assign sclk_sync  = pin_sync_q[PIN_SCLK];
  assign sel_n_sync = pin_sync_q[PIN_SEL];
  assign transmit_enable_sync  = pin_sync_q[PIN_TRANSMIT_ENABLE];
  assign sda_sync   = pin_sync_q[PIN_SDA];

  // edge history; reset to the idle levels of the pins
  // so that no false edge follows reset
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      sclk_d1_q  <= 1'b0;
      sel_n_d1_q <= 1'b1;
    end else begin
      sclk_d1_q  <= sclk_sync;
      sel_n_d1_q <= sel_n_sync;
    end
  end

  // a bit is taken only on a clock rise while selected
  assign sclk_rise = sclk_sync & ~sclk_d1_q & ~sel_n_sync;
  assign sel_rise  = sel_n_sync & ~sel_n_d1_q;

  // frame assembly, msb first; cleared while deselected
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || sel_n_sync) begin
      shift_q <= 12'h000;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[10:0], sda_sync};
    end
  end

  // bit counter saturates so an overlong frame never wraps back to twelve
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || sel_n_sync) begin
      count_q <= 4'h0;
    end else if (sclk_rise && count_q != 4'hF) begin
      count_q <= count_q + 4'h1;
    end
  end

  // frame fields; short or long frames and unknown addresses hit nothing
  assign frame_full = (count_q == 4'(`FRAME_BITS));
  assign frame_addr = shift_q[`FRAME_BITS-1:`DATA_BITS];
  assign frame_data = shift_q[`DATA_BITS-1:0];
  assign hit_pg     = sel_rise && frame_full && (frame_addr == `ADDR_POWER_GAIN);
  assign hit_init   = sel_rise && frame_full && (frame_addr == `ADDR_INIT);

  // pending power/gain: loaded only at select rise, so codes shifted
  // in earlier never reach the amplifier in mid-frame
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pend_pg_q <= {`POWER_CODE_RST, `GAIN_CODE_RST};
    end else if (hit_pg) begin
      pend_pg_q <= frame_data;
    end
  end

  // pending init value
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pend_init_q <= `INIT_RST;
    end else if (hit_init) begin
      pend_init_q <= frame_data;
    end
  end

  // one-cycle apply strobe for power/gain
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pend_pg_v_q <= 1'b0;
    end else begin
      pend_pg_v_q <= hit_pg;
    end
  end

  // one-cycle apply strobe for init
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pend_init_v_q <= 1'b0;
    end else begin
      pend_init_v_q <= hit_init;
    end
  end

  // one decibel per code step, code 63 is 36 dB
  assign gain_db_next = 7'(pend_pg_q[`GAIN_CODE_HI:`GAIN_CODE_LO]) - 7'(`GAIN_DB_OFFSET);

  // power code applied; any power code goes with any gain code
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      power_code_out <= `POWER_CODE_RST;
    end else if (pend_pg_v_q) begin
      power_code_out <= pend_pg_q[`POWER_CODE_HI:`POWER_CODE_LO];
    end
  end

  // gain code applied
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      gain_code_out <= `GAIN_CODE_RST;
    end else if (pend_pg_v_q) begin
      gain_code_out <= pend_pg_q[`GAIN_CODE_HI:`GAIN_CODE_LO];
    end
  end

  // typical gain in dB, kept in step with the gain code
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      gain_db_out <= 7'(`GAIN_CODE_RST) - 7'(`GAIN_DB_OFFSET);
    end else if (pend_pg_v_q) begin
      gain_db_out <= gain_db_next;
    end
  end

  // init register value; reset leaves it unwritten, not zero
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      init_value_out <= `INIT_RST;
    end else if (pend_init_v_q) begin
      init_value_out <= pend_init_q;
    end
  end

  // done only once zero has really been written
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      init_done_out <= 1'b0;
    end else if (pend_init_v_q) begin
      init_done_out <= (pend_init_q == 8'h00);
    end
  end

  // transmit mode follows the synchronised enable
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      transmit_on_out <= 1'b0;
    end else begin
      transmit_on_out <= transmit_enable_sync;
    end
  end
endmodule // amp_serial_port
`default_nettype wire

// file: core/amp_serial_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "amp_ctl_consts.svh"
module amp_serial_ctrl
  import amp_ctl_pkg::*;
#(
  parameter int unsigned POWERUP_CYC = `POWERUP_WAIT_CYC  // wait before first write
) (
  input  wire logic       mclk_in,     // system clock 100 MHz
  input  wire logic       sys_rst_in,  // sync reset, active high
  input  wire logic [3:0] addr_in,     // register address
  input  wire logic [15:0] wdata_in,   // write data
  input  wire logic       wr_in,       // write strobe
  input  wire logic       rd_in,       // read strobe
  output logic [15:0]     rdata_out,   // read data, one cycle later
  amp_link_if.ctrl        link         // serial link to amplifier
);
  ctl_state_t  state_q;
  logic [16:0] wait_q;
  logic [11:0] frame_q;
  logic [3:0]  bits_q;
  logic [2:0]  div_q;
  logic        ready_q, transmit_enable_q, sclk_q;
  logic        busy, half_tick;

  // 80 ns half period gives a 160 ns link clock
  assign half_tick = (div_q == 3'(`LINK_HALF_CYC - 1));

  // divider held at zero while idle, so each frame opens with a full low half
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || state_q == CTL_IDLE) begin
      div_q <= 3'h0;
    end else begin
      div_q <= half_tick ? 3'h0 : div_q + 3'h1;
    end
  end

  // power-up wait; command writes refused until it expires
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      wait_q  <= 17'h00000;
      ready_q <= 1'b0;
    end else if (wait_q == 17'(POWERUP_CYC)) begin
      ready_q <= 1'b1;
    end else begin
      wait_q <= wait_q + 17'h00001;
    end
  end

  // transmit enable register; raising it during a frame is refused,
  // so select always rises between bursts
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      transmit_enable_q <= 1'b0;
    end else if (wr_in && addr_in == `CTL_REG_TRANSMIT_ENABLE && !(busy && wdata_in[0])) begin
      transmit_enable_q <= wdata_in[0];
    end
  end

  // frame engine: select low, 12 clocks msb first, select high
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      state_q <= CTL_IDLE;
      frame_q <= 12'h000;
      bits_q  <= 4'h0;
      sclk_q  <= 1'b0;
    end else begin
      unique case (state_q)
        CTL_IDLE: begin
          // command refused while busy, before the wait, or while transmitting
          if (wr_in && addr_in == `CTL_REG_CMD && ready_q && !transmit_enable_q) begin
            frame_q <= wdata_in[11:0];
            bits_q  <= 4'h0;
            state_q <= CTL_SHIFT;
          end
        end
        CTL_SHIFT: begin
          if (half_tick) begin
            sclk_q <= ~sclk_q;
            if (sclk_q) begin // falling edge moves to next bit
              frame_q <= {frame_q[10:0], 1'b0};
              if (bits_q == 4'(`FRAME_BITS - 1)) begin
                state_q <= CTL_END;
              end
              bits_q <= bits_q + 4'h1;
            end
          end
        end
        CTL_END: begin
          if (half_tick) begin
            state_q <= CTL_IDLE; // select rose on entry to CTL_END; amp has applied
          end
        end
        default: state_q <= CTL_IDLE;
      endcase
    end
  end

  assign busy = (state_q != CTL_IDLE);

  // read port
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rdata_out <= 16'h0000;
    end else if (rd_in) begin
      unique case (addr_in)
        `CTL_REG_CMD:    rdata_out <= {4'h0, frame_q};
        `CTL_REG_STATUS: rdata_out <= {14'h0000, ready_q, busy};
        `CTL_REG_TRANSMIT_ENABLE:   rdata_out <= {15'h0000, transmit_enable_q};
        default:         rdata_out <= 16'h0000;
      endcase
    end
  end

  assign link.sclk            = sclk_q;
  assign link.sdata           = frame_q[11];
  assign link.sel_n           = ~(state_q == CTL_SHIFT);
  assign link.transmit_enable = transmit_enable_q;
endmodule // amp_serial_ctrl
`default_nettype wire

// file: sim/amp_link_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module amp_link_assertions #(
  parameter int unsigned POWERUP_CYC = 20  // wait before first frame
) (
  input wire logic mclk_in,         // system clock
  input wire logic sys_rst_in,      // sync reset, active high
  input wire logic sclk,            // link clock
  input wire logic sdata,           // link data
  input wire logic sel_n,           // select, active low
  input wire logic transmit_enable  // transmit enable
);
  logic [3:0]  rises_q;  // sclk rises in this frame
  logic [15:0] up_q;     // cycles since reset, saturating
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  // bit counter, cleared while deselected
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || sel_n) rises_q <= 4'h0;
    else if (sclk && !$past(sclk)) rises_q <= rises_q + 4'h1;
  end
  // saturates so a long run never wraps into a false early frame
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) up_q <= 16'h0;
    else if (up_q != 16'hFFFF) up_q <= up_q + 16'h1;
  end
  chk_frame_bits: assert property ($rose(sel_n) |-> rises_q == 4'hC)
    else $error("frame closed without twelve bits");
  chk_sclk_idle: assert property (sel_n |-> !sclk)
    else $error("link clock moves while deselected");
  chk_sel_transmit_enable: assert property ($fell(sel_n) |-> !transmit_enable)
    else $error("frame started during transmit");
  chk_sdata_hold: assert property ((!sel_n && sclk) |-> $stable(sdata))
    else $error("data moved while clock high");
  chk_sclk_high: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("clock high time wrong");
  chk_sclk_low: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("clock low time too short");
  chk_frame_span: assert property ($fell(sel_n) |-> ##[150:260] $rose(sel_n))
    else $error("frame length out of range");
  chk_powerup_wait: assert property ($fell(sel_n) |-> up_q >= POWERUP_CYC)
    else $error("frame before power-up wait");
  chk_transmit_enable_frame: assert property (!sel_n |-> !transmit_enable)
    else $error("transmit enable high during a frame");
endmodule // amp_link_assertions
`default_nettype wire

// file: sim/upstream_amp_serial_control_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module upstream_amp_serial_control_tb_top;
  logic              mclk_in = 1'b0, sys_rst_in = 1'b1, wr_s = 1'b0, rd_s = 1'b0, sclk_p = 1'b0;
  logic [3:0]        addr = 4'h0;
  logic [15:0]       wdata = 16'h0, rdata;
  logic [1:0]        pc;
  logic [5:0]        gc;
  logic signed [6:0] db;
  logic [7:0]        iv;
  logic              idn, txo;
  logic [11:0]       sh_q = 12'h0;
  logic [5:0]        gt [4] = '{6'h00, 6'h1B, 6'h3E, 6'h3F};
  int                n_mismatch = 0, cmp_count = 0;
  amp_link_if lk ();
  amp_serial_ctrl #(.POWERUP_CYC(20)) u_amp_serial_ctrl (.mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr_s),
    .rd_in(rd_s), .rdata_out(rdata), .link(lk.ctrl));
  amp_serial_port u_amp_serial_port (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .link(lk.amp), .power_code_out(pc), .gain_code_out(gc), .gain_db_out(db),
    .init_value_out(iv), .init_done_out(idn), .transmit_on_out(txo));
  amp_link_assertions #(.POWERUP_CYC(20)) u_amp_link_assertions (.mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in), .sclk(lk.sclk), .sdata(lk.sdata), .sel_n(lk.sel_n),
    .transmit_enable(lk.transmit_enable));
  initial begin
    forever #5 mclk_in = ~mclk_in;
  end
  // what the wire carries: one bit per clock rise while selected
  always @(posedge mclk_in) begin
    sclk_p <= lk.sclk;
    if (!lk.sel_n && lk.sclk && !sclk_p) sh_q <= {sh_q[10:0], lk.sdata};
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge mclk_in);
    wr_s <= 1'b0;
  endtask
  // read data stand from the cycle after the strobe until the next read
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge mclk_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk_in);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask
  // poll until ready and idle, send, then follow the frame on the wire
  task automatic send(input logic [11:0] f);
    logic [15:0] v;
    logic [5:0]  g0;
    v = 16'h1;
    for (int i = 0; i < 60 && v[1:0] !== 2'b10; i++) rd(4'h1, v);
    g0 = gc;
    wr(4'h0, {4'h0, f});
    for (int i = 0; i < 30 && lk.sel_n !== 1'b0; i++) @(posedge mclk_in);
    for (int i = 0; i < 300 && lk.sel_n !== 1'b1; i++) @(posedge mclk_in);
    chk("held gain", {10'h0, g0}, {10'h0, gc});
    chk("wire frame", {4'h0, f}, {4'h0, sh_q});
    repeat (8) @(posedge mclk_in);
  endtask
  task automatic outs(input logic [1:0] p, input logic [5:0] g);
    chk("power", {14'h0, p}, {14'h0, pc});
    chk("gain", {10'h0, g}, {10'h0, gc});
    chk("gain db", {9'h0, 7'(g) - 7'h1B}, {9'h0, db});
  endtask
  // main sequence
  initial begin
    logic [15:0] v;
    repeat (6) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    outs(2'h3, 6'h3F);
    chk("init done", 16'h0, {15'h0, idn});
    chk("init reset", 16'hFF, {8'h0, iv});
    rd(4'h1, v);
    chk("status early", 16'h0, v);
    wr(4'h0, 16'h0000);
    rd(4'h1, v);
    chk("status refused", 16'h0, v);
    send(12'h100);
    chk("init", 16'h0, {8'h0, iv});
    chk("init done", 16'h1, {15'h0, idn});
    for (int k = 0; k < 4; k++) begin
      send({4'h0, 2'(k), gt[k]});
      outs(2'(k), gt[k]);
    end
    send(12'h2A5);
    outs(2'h3, 6'h3F);
    chk("init", 16'h0, {8'h0, iv});
    wr(4'h0, 16'h00FF);
    wr(4'h2, 16'h1);
    rd(4'h2, v);
    chk("transmit_enable mid frame", 16'h0, {15'h0, v[0]});
    repeat (220) @(posedge mclk_in);
    outs(2'h3, 6'h3F);
    wr(4'h2, 16'h1);
    repeat (8) @(posedge mclk_in);
    chk("tx on", 16'h1, {15'h0, txo});
    rd(4'h2, v);
    chk("transmit_enable reg", 16'h1, {15'h0, v[0]});
    wr(4'h0, 16'h0000);
    repeat (250) @(posedge mclk_in);
    outs(2'h3, 6'h3F);
    wr(4'h2, 16'h0);
    repeat (8) @(posedge mclk_in);
    chk("tx off", 16'h0, {15'h0, txo});
    finish_test;
  end
  // a hang counts against the run
  initial begin
    #400000;
    n_mismatch++;
    finish_test;
  end
endmodule // upstream_amp_serial_control_tb_top
`default_nettype wire
